// [hdl/edge_time_capture.v]
// Edge time capture unit: free-running tick counter captured on pin edges.
`timescale 1ns/1ps
// Functional notes
// - Eight-bit free-running counter advances each tick, wraps.
// - Three-bit scale selects 2us to 16us tick.
// - Rising edge captures count, sets rising full.
// - Falling edge captures count, sets falling full.
// - Reading rising value clears rising full.
// - Reading falling value clears falling full.
// - Clear-on-edge mode restarts counter on edges.
// - Overflow flag needs both enables and wrap.
// - Writing zero clears overflow; one ignored.
// - Falling edge interrupt needs global and falling enable.
// - Rising edge interrupt needs global and rising enable.
// - Status: overflow bit4, falling bit1, rising bit0.
// - Control bits 5,4,1,0 reset to zero.
// - Reset, including bus reset, zeroes all state.
// - Capture interrupt flag bit4, cleared by zero write.
`include "edge_time_capture_defines.vh"

module edge_time_capture (
	// Clock and reset
	input wire clock,
	input wire rstn,
	input wire bus_reset,
	// Register port
	input wire [7:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	output reg [7:0] rdata,
	// Capture pin and interrupts
	input wire capture_input_pin,
	input wire irq_serviced,
	output wire capture_irq,
	output wire irq
);

// -----------------------------------------------------------------------------
// Reset and decode
// -----------------------------------------------------------------------------
wire clr_all = !rstn || bus_reset;
wire wr_status = wr && (addr == `ADDR_STATUS);
wire wr_control = wr && (addr == `ADDR_CONTROL);
wire wr_scale = wr && (addr == `ADDR_SCALE);
wire wr_iclr = wr && (addr == `ADDR_IRQ_CLEAR);
wire wr_ien = wr && (addr == `ADDR_IRQ_ENABLE);
wire rd_rise = rd && (addr == `ADDR_RISE_VAL);
wire rd_fall = rd && (addr == `ADDR_FALL_VAL);

// -----------------------------------------------------------------------------
// Pin synchroniser
// -----------------------------------------------------------------------------
// Three stages; a change is accepted when the last two agree, which also
// keeps the first stage read only by the second.
reg sync1_q;
reg sync2_q;
reg sync3_q;
reg pin_q;
always @(posedge clock) begin
	if (clr_all) begin
		sync1_q <= 1'b0;
		sync2_q <= 1'b0;
		sync3_q <= 1'b0;
		pin_q <= 1'b0;
	end else begin
		sync1_q <= capture_input_pin;
		sync2_q <= sync1_q;
		sync3_q <= sync2_q;
		if (sync2_q == sync3_q) begin
			pin_q <= sync3_q;
		end
	end
end
wire pin_d = (sync2_q == sync3_q) ? sync3_q : pin_q;
wire rise_edge = pin_d && !pin_q;
wire fall_edge = !pin_d && pin_q;
wire any_edge = rise_edge || fall_edge;

// -----------------------------------------------------------------------------
// Control registers
// -----------------------------------------------------------------------------
reg [7:0] control_q;
reg [2:0] scale_q;
reg [`EV_W-1:0] ien_q;
always @(posedge clock) begin
	if (clr_all) begin
		control_q <= `ZERO8;
		scale_q <= 3'h0;
		ien_q <= `ZERO5;
	end else begin
		if (wr_control) begin
			control_q <= wdata & 8'hB3;
		end
		if (wr_scale) begin
			scale_q <= wdata[2:0];
		end
		if (wr_ien) begin
			ien_q <= wdata[`EV_W-1:0];
		end
	end
end
wire clear_on_edge = control_q[`CT_CLR_EDGE];
wire overflow_enable = control_q[`CT_OVF_EN];
wire rising_irq_enable = control_q[`CT_RISE_IRQ];
wire falling_irq_enable = control_q[`CT_FALL_IRQ];
wire capture_global_irq_enable = control_q[`CT_GLOBAL_IRQ];

// -----------------------------------------------------------------------------
// Tick prescaler and counter
// -----------------------------------------------------------------------------
// The tick is (scale+1) times the base period in system clocks.
wire [`DIV_W-1:0] base_cyc = `BASE_TICK_CYC;
wire [`DIV_W-1:0] tick_len = base_cyc * ({8'h00, scale_q} + 11'h001);
reg [`DIV_W-1:0] div_q;
reg [7:0] count_q;
wire tick = (div_q >= tick_len - 11'h001);
always @(posedge clock) begin
	if (clr_all) begin
		div_q <= {`DIV_W{1'b0}};
		count_q <= `ZERO8;
	end else if (clear_on_edge && any_edge) begin
		// Restart the tick too, so the measured width is phase-exact.
		div_q <= {`DIV_W{1'b0}};
		count_q <= `ZERO8;
	end else if (tick) begin
		div_q <= {`DIV_W{1'b0}};
		count_q <= count_q + 8'h01;
	end else begin
		div_q <= div_q + 11'h001;
	end
end
wire wrap = tick && (count_q == `CNT_MAX) && !(clear_on_edge && any_edge);

// -----------------------------------------------------------------------------
// Capture registers and status flags
// -----------------------------------------------------------------------------
reg [7:0] rise_val_q;
reg [7:0] fall_val_q;
reg rising_capture_full_q;
reg falling_capture_full_q;
reg overflow_flag_q;
reg capture_flag_q;
wire capture_set = (rise_edge && rising_irq_enable) || (fall_edge && falling_irq_enable);
always @(posedge clock) begin
	if (clr_all) begin
		rise_val_q <= `ZERO8;
		fall_val_q <= `ZERO8;
		rising_capture_full_q <= 1'b0;
		falling_capture_full_q <= 1'b0;
		overflow_flag_q <= 1'b0;
		capture_flag_q <= 1'b0;
	end else begin
		// Capture uses the count before any clear in this cycle.
		if (rise_edge) begin
			rise_val_q <= count_q;
			rising_capture_full_q <= 1'b1;
		end else if (rd_rise) begin
			rising_capture_full_q <= 1'b0;
		end
		if (fall_edge) begin
			fall_val_q <= count_q;
			falling_capture_full_q <= 1'b1;
		end else if (rd_fall) begin
			falling_capture_full_q <= 1'b0;
		end
		if (wrap && clear_on_edge && overflow_enable) begin
			overflow_flag_q <= 1'b1;
		end else if (wr_status && !wdata[`ST_OVERFLOW]) begin
			overflow_flag_q <= 1'b0;
		end
		if (capture_set) begin
			capture_flag_q <= 1'b1;
		end else if (irq_serviced || (wr_status && !wdata[`EV_CAPTURE])) begin
			capture_flag_q <= 1'b0;
		end
	end
end
// Global enable gates the request line, so a flag may stand while masked.
assign capture_irq = capture_flag_q && capture_global_irq_enable;

// -----------------------------------------------------------------------------
// Event status, enable and clear
// -----------------------------------------------------------------------------
reg [`EV_W-1:0] ev_q;
wire [`EV_W-1:0] ev_set;
assign ev_set[`EV_RISE] = rise_edge;
assign ev_set[`EV_FALL] = fall_edge;
assign ev_set[`EV_OVF] = wrap && clear_on_edge && overflow_enable;
assign ev_set[3] = 1'b0;
assign ev_set[`EV_CAPTURE] = capture_set && capture_global_irq_enable;
always @(posedge clock) begin
	if (clr_all) begin
		ev_q <= `ZERO5;
	end else begin
		// A new event wins over a clear in the same cycle.
		ev_q <= (ev_q & ~(wr_iclr ? wdata[`EV_W-1:0] : `ZERO5)) | ev_set;
	end
end
assign irq = |(ev_q & ien_q);

// -----------------------------------------------------------------------------
// Read port
// -----------------------------------------------------------------------------
reg [7:0] rdata_d;
always @* begin
	rdata_d = `ZERO8;
	case (addr)
	`ADDR_STATUS: begin
		rdata_d[`ST_OVERFLOW] = overflow_flag_q;
		rdata_d[`ST_FALL_FULL] = falling_capture_full_q;
		rdata_d[`ST_RISE_FULL] = rising_capture_full_q;
	end
	`ADDR_CONTROL: begin
		rdata_d = control_q;
	end
	`ADDR_SCALE: begin
		rdata_d = {5'h00, scale_q};
	end
	`ADDR_RISE_VAL: begin
		rdata_d = rise_val_q;
	end
	`ADDR_FALL_VAL: begin
		rdata_d = fall_val_q;
	end
	`ADDR_IRQ_STATUS: begin
		rdata_d = {3'h0, ev_q};
	end
	`ADDR_IRQ_ENABLE: begin
		rdata_d = {3'h0, ien_q};
	end
	default: begin
		rdata_d = `ZERO8;
	end
	endcase
end
always @(posedge clock) begin
	if (clr_all) begin
		rdata <= `ZERO8;
	end else if (rd) begin
		rdata <= rdata_d;
	end else begin
		rdata <= `ZERO8;
	end
end

endmodule

// [hdl/edge_time_capture_defines.vh]
// Constants for the edge time capture unit: register map, fields, timing.
`ifndef EDGE_TIME_CAPTURE_DEFINES_VH
`define EDGE_TIME_CAPTURE_DEFINES_VH

// -----------------------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------------------
`define ADDR_STATUS 8'hC8
`define ADDR_CONTROL 8'hC9
`define ADDR_SCALE 8'hCA
`define ADDR_RISE_VAL 8'hCB
`define ADDR_FALL_VAL 8'hCC
`define ADDR_IRQ_STATUS 8'hD0
`define ADDR_IRQ_CLEAR 8'hD1
`define ADDR_IRQ_ENABLE 8'hD2

// -----------------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------------
`define ST_RISE_FULL 0
`define ST_FALL_FULL 1
`define ST_OVERFLOW 4
`define CT_RISE_IRQ 0
`define CT_FALL_IRQ 1
`define CT_OVF_EN 4
`define CT_CLR_EDGE 5
`define CT_GLOBAL_IRQ 7
`define EV_RISE 0
`define EV_FALL 1
`define EV_OVF 2
`define EV_CAPTURE 4
`define EV_W 5

// -----------------------------------------------------------------------------
// Reset values and timing
// -----------------------------------------------------------------------------
`define ZERO8 8'h00
`define ZERO5 5'h00
`define CLK_MHZ 50
`define BASE_TICK_US 2
// Base tick in system clocks: 2 us at 50 MHz, sized to the divider width.
`define BASE_TICK_CYC 11'h064
`define DIV_W 11
`define CNT_MAX 8'hFF

`endif

// [bench/etc_props.sv]
// Property checker for the edge time capture unit.
`timescale 1ns/1ps
`include "edge_time_capture_defines.vh"
module etc_props (
	// Clock and reset
	input wire clock,
	input wire rstn,
	input wire bus_reset,
	// Register port
	input wire [7:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	input wire [7:0] rdata,
	// Pin and interrupts
	input wire capture_input_pin,
	input wire irq_serviced,
	input wire capture_irq,
	input wire irq
);
	// Cycles since the pin moved; above five no edge is left in the synchroniser.
	logic [2:0] calm_q = 3'h0;
	always @(posedge clock) begin
		if ($changed(capture_input_pin))
			calm_q <= 3'h0;
		else if (calm_q != 3'h7)
			calm_q <= calm_q + 3'h1;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn || bus_reset);
	a_read_window: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("read data outside its cycle");
	a_status_reserved: assert property (rd && addr == `ADDR_STATUS |=> (rdata & 8'hEC) == 8'h00)
		else $error("status reserved bits set");
	a_control_reserved: assert property (rd && addr == `ADDR_CONTROL |=> (rdata & 8'h4C) == 8'h00)
		else $error("control reserved bits set");
	a_scale_reserved: assert property (rd && addr == `ADDR_SCALE |=> (rdata & 8'hF8) == 8'h00)
		else $error("scale reserved bits set");
	a_reset_quiet: assert property (disable iff (1'b0) !rstn |=> rdata == 8'h00 && !irq && !capture_irq)
		else $error("outputs active after reset");
	a_serviced_clears: assert property (irq_serviced && calm_q > 3'h5 |=> !capture_irq)
		else $error("capture request kept after service");
	a_rise_read_clears: assert property (rd && addr == `ADDR_RISE_VAL && calm_q > 3'h5 ##2
		rd && addr == `ADDR_STATUS |=> !rdata[0])
		else $error("rising full kept after read");
	a_fall_read_clears: assert property (rd && addr == `ADDR_FALL_VAL && calm_q > 3'h5 ##2
		rd && addr == `ADDR_STATUS |=> !rdata[1])
		else $error("falling full kept after read");
endmodule
bind edge_time_capture etc_props chk (.clock(clock), .rstn(rstn), .bus_reset(bus_reset),
	.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.capture_input_pin(capture_input_pin), .irq_serviced(irq_serviced),
	.capture_irq(capture_irq), .irq(irq));

// [bench/pulse_source.sv]
// Model of the external pulse source that drives the capture pin.
`timescale 1ns/1ps
module pulse_source (
	// Requested level
	input wire want,
	// Capture pin
	output wire pin
);
	// The source is unrelated to the clock, so its edges land between clock edges.
	assign #7 pin = want;
endmodule

// [bench/testbench.sv]
// Self-checking bench for the edge time capture unit.
`timescale 1ns/1ps
`include "edge_time_capture_defines.vh"
module testbench;
	logic clock = 0, rstn = 0, bus_reset = 0, wr = 0, rd = 0, irq_serviced = 0, want = 0;
	logic [7:0] addr = 8'h00, wdata = 8'h00;
	logic [7:0] regs[6] = '{8'hC8, 8'hC9, 8'hCA, 8'hCB, 8'hCC, 8'h00};
	wire [7:0] rdata;
	wire pin, capture_irq, irq;
	int mismatches = 0, checks_done = 0, cycles = 0;
	always #10 clock = ~clock;
	pulse_source src (.want(want), .pin(pin));
	edge_time_capture dut (.clock(clock), .rstn(rstn), .bus_reset(bus_reset), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .capture_input_pin(pin),
		.irq_serviced(irq_serviced), .capture_irq(capture_irq), .irq(irq));
	task summarize;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1;
		@(posedge clock);
		wr <= 0;
		#1;
	endtask
	task rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
		@(posedge clock);
		addr <= a;
		rd <= 1;
		@(posedge clock);
		rd <= 0;
		#1 chk($sformatf("register %h", a), exp, rdata & m);
	endtask
	task move(input logic v, input int n);
		@(posedge clock);
		want <= v;
		repeat (n) @(posedge clock);
		#1;
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 60000) begin
			mismatches++;
			summarize();
		end
	end
	initial begin
		repeat (5) @(posedge clock);
		rstn <= 1;
		foreach (regs[i]) rd_chk(regs[i], 8'h00, 8'hFF);
		wr_reg(`ADDR_CONTROL, 8'hFF);
		rd_chk(`ADDR_CONTROL, 8'hB3, 8'hFF);
		wr_reg(`ADDR_SCALE, 8'hFF);
		rd_chk(`ADDR_SCALE, 8'h07, 8'hFF);
		wr_reg(`ADDR_SCALE, 8'h00);
		wr_reg(`ADDR_CONTROL, 8'hA3);
		$display("test registers done");
		move(1, 20);
		move(0, 550);
		move(1, 250);
		move(0, 20);
		rd_chk(`ADDR_STATUS, 8'h03, 8'hFF);
		chk("capture_irq", 8'h01, 8'(capture_irq));
		rd_chk(`ADDR_RISE_VAL, 8'h05, 8'hFF);
		rd_chk(`ADDR_FALL_VAL, 8'h02, 8'hFF);
		rd_chk(`ADDR_STATUS, 8'h00, 8'hFF);
		rd_chk(`ADDR_IRQ_STATUS, 8'h13, 8'hFF);
		wr_reg(`ADDR_IRQ_ENABLE, 8'h17);
		chk("irq", 8'h01, 8'(irq));
		wr_reg(`ADDR_IRQ_ENABLE, 8'h10);
		chk("irq", 8'h01, 8'(irq));
		wr_reg(`ADDR_IRQ_ENABLE, 8'h00);
		chk("irq", 8'h00, 8'(irq));
		wr_reg(`ADDR_IRQ_ENABLE, 8'h17);
		wr_reg(`ADDR_IRQ_CLEAR, 8'hFF);
		chk("irq", 8'h00, 8'(irq));
		wr_reg(`ADDR_STATUS, 8'h10);
		chk("capture_irq", 8'h01, 8'(capture_irq));
		wr_reg(`ADDR_STATUS, 8'h00);
		chk("capture_irq", 8'h00, 8'(capture_irq));
		$display("test capture done");
		wr_reg(`ADDR_CONTROL, 8'hA2);
		move(1, 20);
		chk("capture_irq", 8'h00, 8'(capture_irq));
		move(0, 20);
		chk("capture_irq", 8'h01, 8'(capture_irq));
		@(posedge clock);
		irq_serviced <= 1;
		@(posedge clock);
		irq_serviced <= 0;
		#1 chk("capture_irq", 8'h00, 8'(capture_irq));
		$display("test enables done");
		wr_reg(`ADDR_CONTROL, 8'h30);
		move(1, 26000);
		rd_chk(`ADDR_STATUS, 8'h10, 8'h10);
		wr_reg(`ADDR_STATUS, 8'h10);
		rd_chk(`ADDR_STATUS, 8'h10, 8'h10);
		wr_reg(`ADDR_STATUS, 8'h00);
		rd_chk(`ADDR_STATUS, 8'h00, 8'h10);
		wr_reg(`ADDR_SCALE, 8'h07);
		move(0, 2500);
		move(1, 20);
		rd_chk(`ADDR_RISE_VAL, 8'h03, 8'hFF);
		rd_chk(`ADDR_STATUS, 8'h00, 8'h01);
		$display("test overflow and scale done");
		@(posedge clock);
		bus_reset <= 1;
		@(posedge clock);
		bus_reset <= 0;
		rd_chk(`ADDR_SCALE, 8'h00, 8'hFF);
		$display("test bus reset done");
		summarize();
	end
endmodule
